// ==== rtl/pcs_config_status.sv ====
// Configuration status and class code registers with error and interrupt pins
//
// Overview of operation
// - Address or data parity error sets bit 15
// - Bit 14 set on signalled system error, enabled
// - Master abort on own cycle sets bit 13
// - Received target abort sets bit 12
// - Own signalled target abort sets bit 11
// - Devsel timing bits read medium code 01b
// - Bit 8 needs PERR, mastership and enable
// - Bits 7, 6, 5 always read zero
// - Bit 4 always reads one
// - Bit 3 mirrors interrupt; INTx gated by disable
// - Interrupt disable blocks INTx, not bit 3
// - Feature enable low forces bit 3 zero
// - Reserved bits 2 to 0 read zero
// - Base class byte reads serial bus code
// - Subclass byte reads 1394 controller code
// - Programming interface byte reads OHCI code
// - Lowest byte is fixed silicon revision
// - Interrupt disable set keeps INTx deasserted
// - Parity response enable gates PERR driving
`timescale 1ns/1ps
module pcs_config_status #(
    // Arbitrary value, stands in for the chip revision
    parameter logic [7:0] SILICON_VERSION_CODE = 8'h5A
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [5:0]  cfg_idx,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_ack,
    output logic             cfg_hit,
    input  wire logic        int_disable,
    input  wire logic        serr_enable,
    input  wire logic        parity_response_enable,
    input  wire logic        rev23_feature_enable,
    input  wire logic        addr_parity_err,
    input  wire logic        data_parity_err,
    input  wire logic        perr_seen,
    input  wire logic        bus_master_phase,
    input  wire logic        master_abort_received,
    input  wire logic        target_abort_received,
    input  wire logic        target_abort_signalled,
    input  wire logic        func_int_pending,
    output logic      [1:0]  devsel_timing,
    output logic             perr_n_o,
    output logic             perr_oe_n,
    output logic             serr_n_o,
    output logic             serr_oe_n,
    output logic             intx_n_o,
    output logic             intx_oe_n
);

    typedef struct packed {
        pcs_pkg::pcs_state_e state;
        logic [31:0]         rdata;
        logic                hit;
        logic                int_status;
        logic                intx_drive;
    } pcs_main_s;

    pcs_main_s                       st_ff;
    pcs_main_s                       nxt_st;

    logic [pcs_pkg::FLAG_N-1:0]      flag_set;
    logic [pcs_pkg::FLAG_N-1:0]      flag_clr;
    logic [pcs_pkg::FLAG_N-1:0]      flags;
    logic [pcs_pkg::PIN_N-1:0]       pin_req;
    logic [pcs_pkg::PIN_N-1:0]       pin_o;
    logic [pcs_pkg::PIN_N-1:0]       pin_oe_n;

    logic                            perr_req;
    logic                            serr_req;
    logic                            int_status_now;
    logic                            int_gate;
    logic                            status_wr;
    logic [15:0]                     status_wdata;
    logic [15:0]                     status_lane_mask;
    logic [15:0]                     status_rd;
    logic [31:0]                     class_rd;
    logic                            class_hit;
    logic                            status_hit;
    logic                            take;

    // Error pin requests
    always_comb begin
        // PERR is only driven when parity response is enabled
        perr_req = data_parity_err & parity_response_enable;
        // SERR reports address parity errors when its driver is enabled
        serr_req = addr_parity_err & serr_enable;
    end

    // Sticky flag set events
    always_comb begin
        flag_set = '0;
        // Either phase type counts as detected parity
        flag_set[pcs_pkg::FL_PARITY_SEEN]  = addr_parity_err | data_parity_err;
        // Only a system error this block actually signalled
        flag_set[pcs_pkg::FL_SERR_SENT]    = serr_req;
        flag_set[pcs_pkg::FL_MST_ABORT]    = master_abort_received;
        flag_set[pcs_pkg::FL_TGT_ABORT_RX] = target_abort_received;
        flag_set[pcs_pkg::FL_TGT_ABORT_TX] = target_abort_signalled;
        // All three conditions must meet in one cycle
        flag_set[pcs_pkg::FL_DATA_PAR]     = perr_seen & bus_master_phase
                                             & parity_response_enable;
    end

    // Configuration access decode
    always_comb begin
        take       = (cfg_rd | cfg_wr) & (st_ff.state == pcs_pkg::PCS_IDLE);
        class_hit  = 1'b0;
        status_hit = 1'b0;
        if (cfg_idx == pcs_pkg::CLASS_IDX) begin
            class_hit = 1'b1;
        end else if (cfg_idx == pcs_pkg::STATUS_IDX) begin
            status_hit = 1'b1;
        end
    end

    // Status write-one-to-clear, honouring byte lanes
    always_comb begin
        status_wr        = take & cfg_wr & status_hit;
        status_wdata     = cfg_wdata[31:16];
        status_lane_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}};
        flag_clr         = '0;
        if (status_wr) begin
            // Only a written one clears; zeros leave flags alone
            flag_clr[pcs_pkg::FL_PARITY_SEEN]  =
                status_wdata[pcs_pkg::ST_PARITY_SEEN] & status_lane_mask[pcs_pkg::ST_PARITY_SEEN];
            flag_clr[pcs_pkg::FL_SERR_SENT]    =
                status_wdata[pcs_pkg::ST_SERR_SENT] & status_lane_mask[pcs_pkg::ST_SERR_SENT];
            flag_clr[pcs_pkg::FL_MST_ABORT]    =
                status_wdata[pcs_pkg::ST_MST_ABORT] & status_lane_mask[pcs_pkg::ST_MST_ABORT];
            flag_clr[pcs_pkg::FL_TGT_ABORT_RX] =
                status_wdata[pcs_pkg::ST_TGT_ABORT_RX]
                & status_lane_mask[pcs_pkg::ST_TGT_ABORT_RX];
            flag_clr[pcs_pkg::FL_TGT_ABORT_TX] =
                status_wdata[pcs_pkg::ST_TGT_ABORT_TX]
                & status_lane_mask[pcs_pkg::ST_TGT_ABORT_TX];
            flag_clr[pcs_pkg::FL_DATA_PAR]     =
                status_wdata[pcs_pkg::ST_DATA_PAR] & status_lane_mask[pcs_pkg::ST_DATA_PAR];
        end
    end

    pcs_sticky_flags u_flags (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .set_pulse (flag_set),
        .clr_mask  (flag_clr),
        .flags     (flags)
    );

    // Interrupt status and INTx gating
    always_comb begin
        // Status follows the pending interrupt only with the feature on
        int_status_now = func_int_pending & rev23_feature_enable;
        // Disable is read-only zero without the feature, so it only counts with it
        int_gate       = int_disable & rev23_feature_enable;
        // Disable never touches the status bit itself
    end

    // Status read image
    always_comb begin
        status_rd = '0; // Reserved bits 2 to 0 stay zero
        status_rd[pcs_pkg::ST_PARITY_SEEN]  = flags[pcs_pkg::FL_PARITY_SEEN];
        status_rd[pcs_pkg::ST_SERR_SENT]    = flags[pcs_pkg::FL_SERR_SENT];
        status_rd[pcs_pkg::ST_MST_ABORT]    = flags[pcs_pkg::FL_MST_ABORT];
        status_rd[pcs_pkg::ST_TGT_ABORT_RX] = flags[pcs_pkg::FL_TGT_ABORT_RX];
        status_rd[pcs_pkg::ST_TGT_ABORT_TX] = flags[pcs_pkg::FL_TGT_ABORT_TX];
        status_rd[pcs_pkg::ST_DEVSEL_HI]    = pcs_pkg::DEVSEL_MEDIUM[1];
        status_rd[pcs_pkg::ST_DEVSEL_LO]    = pcs_pkg::DEVSEL_MEDIUM[0];
        status_rd[pcs_pkg::ST_DATA_PAR]     = flags[pcs_pkg::FL_DATA_PAR];
        status_rd[pcs_pkg::ST_FAST_B2B]     = 1'b0;
        status_rd[pcs_pkg::ST_USER_FEAT]    = 1'b0;
        status_rd[pcs_pkg::ST_DOUBLE_SPEED] = 1'b0;
        status_rd[pcs_pkg::ST_CAP_CHAIN]    = 1'b1;
        // Registered copy keeps the read stable for the whole answer cycle
        status_rd[pcs_pkg::ST_INT_STATUS]   = st_ff.int_status;
    end

    // Class code image is constant; writes never reach it
    always_comb begin
        class_rd = {pcs_pkg::CLASS_SERIAL_BUS,
                    pcs_pkg::SUBCLASS_1394,
                    pcs_pkg::PROG_MODEL_OHCI,
                    SILICON_VERSION_CODE};
    end

    // Answer machine and registered outputs
    always_comb begin
        nxt_st            = st_ff;
        nxt_st.int_status = int_status_now;
        // INTx only with status set and disable clear
        nxt_st.intx_drive = int_status_now & ~int_gate;
        case (st_ff.state)
            pcs_pkg::PCS_IDLE: begin
                if (take) begin
                    nxt_st.state = pcs_pkg::PCS_ANSWER;
                    nxt_st.hit   = class_hit | status_hit;
                    nxt_st.rdata = '0;
                    if (cfg_rd && class_hit) begin
                        nxt_st.rdata = class_rd;
                    end else if (cfg_rd && status_hit) begin
                        // Command half lives elsewhere and reads zero here
                        nxt_st.rdata = {status_rd, 16'h0000};
                    end
                end
            end
            pcs_pkg::PCS_ANSWER: begin
                nxt_st.state = pcs_pkg::PCS_IDLE;
            end
            default: begin
                nxt_st.state = pcs_pkg::PCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff.state      <= pcs_pkg::PCS_IDLE;
            st_ff.rdata      <= '0;
            st_ff.hit        <= 1'b0;
            st_ff.int_status <= 1'b0;
            st_ff.intx_drive <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Error pins
    always_comb begin
        pin_req                   = '0;
        pin_req[pcs_pkg::PIN_PERR] = perr_req;
        pin_req[pcs_pkg::PIN_SERR] = serr_req;
    end

    pcs_pin_drive u_pins (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .drive_req(pin_req),
        .pin_o    (pin_o),
        .pin_oe_n (pin_oe_n)
    );

    assign perr_n_o      = pin_o[pcs_pkg::PIN_PERR];
    assign perr_oe_n     = pin_oe_n[pcs_pkg::PIN_PERR];
    assign serr_n_o      = pin_o[pcs_pkg::PIN_SERR];
    assign serr_oe_n     = pin_oe_n[pcs_pkg::PIN_SERR];

    // INTx is open drain: it pulls low or floats
    assign intx_n_o      = 1'b0;
    assign intx_oe_n     = ~st_ff.intx_drive;

    assign cfg_ack       = (st_ff.state == pcs_pkg::PCS_ANSWER);
    assign cfg_rdata     = st_ff.rdata;
    assign cfg_hit       = st_ff.hit & cfg_ack;
    assign devsel_timing = pcs_pkg::DEVSEL_MEDIUM;

endmodule

// ==== rtl/pcs_pin_drive.sv ====
// Registered active-low drivers for the shared error pins
`timescale 1ns/1ps
module pcs_pin_drive (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire logic [pcs_pkg::PIN_N-1:0] drive_req,
    output logic      [pcs_pkg::PIN_N-1:0] pin_o,
    output logic      [pcs_pkg::PIN_N-1:0] pin_oe_n
);

    typedef struct packed {
        logic [pcs_pkg::PIN_N-1:0] drive;
    } pcs_pin_s;

    pcs_pin_s                  st_ff;
    pcs_pin_s                  nxt_st;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.drive = drive_req;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    genvar i;
    generate
        for (i = 0; i < pcs_pkg::PIN_N; i = i + 1) begin : g_pin
            // Pins only ever pull low; release lets the bus pull-up restore them
            assign pin_o[i]    = 1'b0;
            assign pin_oe_n[i] = ~st_ff.drive[i];
        end
    endgenerate

endmodule

// ==== rtl/pcs_pkg.sv ====
// Constants, field positions and types for the configuration status block
package pcs_pkg;

    // Register offsets, byte addresses in configuration space
    localparam logic [7:0]  CLASS_OFF        = 8'h08;
    localparam logic [7:0]  STATUS_OFF       = 8'h06;
    localparam logic [5:0]  CLASS_IDX        = CLASS_OFF[7:2];
    localparam logic [5:0]  STATUS_IDX       = STATUS_OFF[7:2];

    // Status field positions
    localparam int          ST_PARITY_SEEN   = 15;
    localparam int          ST_SERR_SENT     = 14;
    localparam int          ST_MST_ABORT     = 13;
    localparam int          ST_TGT_ABORT_RX  = 12;
    localparam int          ST_TGT_ABORT_TX  = 11;
    localparam int          ST_DEVSEL_HI     = 10;
    localparam int          ST_DEVSEL_LO     = 9;
    localparam int          ST_DATA_PAR      = 8;
    localparam int          ST_FAST_B2B      = 7;
    localparam int          ST_USER_FEAT     = 6;
    localparam int          ST_DOUBLE_SPEED  = 5;
    localparam int          ST_CAP_CHAIN     = 4;
    localparam int          ST_INT_STATUS    = 3;

    // Fixed field values and reset value
    localparam logic [1:0]  DEVSEL_MEDIUM    = 2'h1;
    localparam logic [15:0] STATUS_RST       = 16'h0210;
    localparam logic [7:0]  CLASS_SERIAL_BUS = 8'h0C;
    localparam logic [7:0]  SUBCLASS_1394    = 8'h00;
    localparam logic [7:0]  PROG_MODEL_OHCI  = 8'h10;

    // Sticky flag vector layout
    localparam int          FLAG_N           = 6;
    localparam int          FL_PARITY_SEEN   = 0;
    localparam int          FL_SERR_SENT     = 1;
    localparam int          FL_MST_ABORT     = 2;
    localparam int          FL_TGT_ABORT_RX  = 3;
    localparam int          FL_TGT_ABORT_TX  = 4;
    localparam int          FL_DATA_PAR      = 5;

    // Error pin drivers
    localparam int          PIN_N            = 2;
    localparam int          PIN_PERR         = 0;
    localparam int          PIN_SERR         = 1;

    // Configuration answer machine
    typedef enum logic [1:0] {
        PCS_IDLE   = 2'h1,
        PCS_ANSWER = 2'h2
    } pcs_state_e;

endpackage

// ==== rtl/pcs_sticky_flags.sv ====
// Write-one-to-clear sticky flags with set winning over clear
`timescale 1ns/1ps
module pcs_sticky_flags (
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    input  wire logic [pcs_pkg::FLAG_N-1:0] set_pulse,
    input  wire logic [pcs_pkg::FLAG_N-1:0] clr_mask,
    output logic      [pcs_pkg::FLAG_N-1:0] flags
);

    typedef struct packed {
        logic [pcs_pkg::FLAG_N-1:0] flag;
    } pcs_flag_s;

    pcs_flag_s                  st_ff;
    pcs_flag_s                  nxt_st;
    logic [pcs_pkg::FLAG_N-1:0] nxt_bits;

    genvar i;
    generate
        for (i = 0; i < pcs_pkg::FLAG_N; i = i + 1) begin : g_flag
            // An event in the clearing cycle is kept
            assign nxt_bits[i] = set_pulse[i] | (st_ff.flag[i] & ~clr_mask[i]);
        end
    endgenerate

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.flag = nxt_bits;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flags = st_ff.flag;

endmodule

// ==== verification/pcs_config_status_properties.sv ====
// Concurrent checks on the ports of the configuration status block
`timescale 1ns/1ps
module pcs_config_status_properties #(
    parameter logic [7:0] SILICON_VERSION_CODE = 8'h5A
) (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        cfg_rd,
    input wire logic        cfg_wr,
    input wire logic [5:0]  cfg_idx,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_ack,
    input wire logic        cfg_hit,
    input wire logic        int_disable,
    input wire logic        serr_enable,
    input wire logic        parity_response_enable,
    input wire logic        rev23_feature_enable,
    input wire logic        addr_parity_err,
    input wire logic        data_parity_err,
    input wire logic        func_int_pending,
    input wire logic [1:0]  devsel_timing,
    input wire logic        perr_oe_n,
    input wire logic        serr_oe_n,
    input wire logic        intx_oe_n
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic take_rd;
    assign take_rd = cfg_rd && !cfg_ack;

    answer_strobe_a: assert property ((cfg_rd || cfg_wr) && !cfg_ack |=> cfg_ack ##1 !cfg_ack)
        else $error("answer strobe missing or too long");
    class_fixed_a: assert property (take_rd && cfg_idx == 6'h02 |=> cfg_hit &&
        cfg_rdata == {8'h0C, 8'h00, 8'h10, SILICON_VERSION_CODE})
        else $error("class register read wrong");
    status_fixed_a: assert property (take_rd && cfg_idx == 6'h01 |=> cfg_hit &&
        cfg_rdata[26:25] == 2'h1 && cfg_rdata[23:20] == 4'h1 && cfg_rdata[18:0] == 19'h0)
        else $error("status fixed bits wrong");
    unmapped_read_a: assert property (take_rd && cfg_idx == 6'h00 |=> !cfg_hit && cfg_rdata == 32'h0)
        else $error("unmapped read answered");
    int_status_a: assert property (take_rd && cfg_idx == 6'h01 |=>
        cfg_rdata[19] == $past(func_int_pending && rev23_feature_enable, 2))
        else $error("interrupt status bit wrong");
    intx_gate_a: assert property ((!intx_oe_n) ==
        ($past(func_int_pending && rev23_feature_enable) &&
         !$past(int_disable && rev23_feature_enable)))
        else $error("interrupt pin drive wrong");
    perr_drive_a: assert property ((!perr_oe_n) == $past(data_parity_err && parity_response_enable))
        else $error("parity error pin drive wrong");
    serr_drive_a: assert property ((!serr_oe_n) == $past(addr_parity_err && serr_enable))
        else $error("system error pin drive wrong");
    devsel_code_a: assert property (devsel_timing == 2'h1)
        else $error("select timing code wrong");
endmodule

// ==== verification/pcs_config_status_tb.sv ====
// Self-checking bench for the configuration status block
`timescale 1ns/1ps
module pcs_config_status_tb;
    localparam logic [7:0] REV = 8'hA3; // Arbitrary value
    logic sys_clk, resetn, cfg_rd, cfg_wr, cfg_ack, cfg_hit;
    logic int_disable, serr_enable, parity_response_enable, rev23_feature_enable;
    logic bus_master_phase, func_int_pending, perr_n_o, perr_oe_n, serr_n_o, serr_oe_n;
    logic intx_n_o, intx_oe_n, wr_h;
    logic [5:0]  cfg_idx, ev;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, wr_d;
    logic [1:0]  devsel_timing;
    logic [15:0] exp_fl;
    int          err_count, total_checks;
    logic [5:0]  ev_tab [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    logic [15:0] fl_tab [6] = '{16'hC000, 16'h8000, 16'h0100, 16'h2000, 16'h1000, 16'h0800};

    pcs_host_model pcs_host_model_inst (.sys_clk, .cfg_rd, .cfg_wr, .cfg_idx, .cfg_be,
        .cfg_wdata, .cfg_rdata, .cfg_hit, .ev);
    pcs_config_status #(.SILICON_VERSION_CODE(REV)) pcs_config_status_inst (.sys_clk, .resetn,
        .cfg_rd, .cfg_wr, .cfg_idx, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .cfg_hit,
        .int_disable, .serr_enable, .parity_response_enable, .rev23_feature_enable,
        .addr_parity_err(ev[0]), .data_parity_err(ev[1]), .perr_seen(ev[2]),
        .bus_master_phase, .master_abort_received(ev[3]), .target_abort_received(ev[4]),
        .target_abort_signalled(ev[5]), .func_int_pending, .devsel_timing, .perr_n_o,
        .perr_oe_n, .serr_n_o, .serr_oe_n, .intx_n_o, .intx_oe_n);

    always #2.5 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic        h;
        pcs_host_model_inst.access(1'b0, idx, 4'hF, 32'h0, d, h);
        check(d, exp, what);
        check({31'h0, h}, {31'h0, idx == 6'h01 || idx == 6'h02}, "hit");
    endtask

    task automatic wr(input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] d;
        logic        h;
        pcs_host_model_inst.access(1'b1, 6'h01, be, wd, d, h);
    endtask

    function automatic logic [31:0] st(input logic ints);
        return {exp_fl | 16'h0210 | {12'h0, ints, 3'h0}, 16'h0};
    endfunction

    task automatic wrap_up;
        $display("Checks: %0d, mismatches: %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #50000;
        err_count++;
        wrap_up();
    end

    initial begin
        {sys_clk, resetn, int_disable, serr_enable, parity_response_enable} = 5'h0;
        {rev23_feature_enable, bus_master_phase, func_int_pending} = 3'h0;
        exp_fl = 16'h0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        check({29'h0, perr_n_o, serr_n_o, intx_n_o}, 32'h0, "pin low levels");
        check({30'h0, devsel_timing}, 32'h1, "select timing");
        rd_chk(6'h01, st(1'b0), "status after reset");
        rd_chk(6'h02, {8'h0C, 8'h00, 8'h10, REV}, "class code");
        pcs_host_model_inst.access(1'b1, 6'h02, 4'hF, 32'hFFFF_FFFF, wr_d, wr_h);
        check(wr_d, 32'h0, "write answer data");
        check({31'h0, wr_h}, 32'h1, "class write hit");
        rd_chk(6'h02, {8'h0C, 8'h00, 8'h10, REV}, "class after write");
        rd_chk(6'h00, 32'h0, "unmapped");
        {serr_enable, parity_response_enable, bus_master_phase} = 3'h7;
        for (int i = 0; i < 6; i++) begin
            pcs_host_model_inst.fire(ev_tab[i]);
            exp_fl = fl_tab[i];
            rd_chk(6'h01, st(1'b0), "event flag");
            wr(4'hC, 32'hFFFF_0000);
            exp_fl = 16'h0;
            rd_chk(6'h01, st(1'b0), "flag cleared");
        end
        serr_enable = 1'b0;
        pcs_host_model_inst.fire(6'h01);
        bus_master_phase = 1'b0;
        pcs_host_model_inst.fire(6'h04);
        {bus_master_phase, parity_response_enable} = 2'h2;
        pcs_host_model_inst.fire(6'h04);
        pcs_host_model_inst.fire(6'h38);
        exp_fl = 16'hB800;
        rd_chk(6'h01, st(1'b0), "gated events");
        wr(4'hF, 32'h0);
        rd_chk(6'h01, st(1'b0), "zero write keeps flags");
        wr(4'hC, 32'h2000_0000);
        exp_fl = 16'h9800;
        rd_chk(6'h01, st(1'b0), "single flag clear");
        wr(4'h4, 32'hFFFF_FFFF);
        rd_chk(6'h01, st(1'b0), "disabled lane keeps flags");
        wr(4'h8, 32'hFFFF_FFFF);
        exp_fl = 16'h0;
        rd_chk(6'h01, st(1'b0), "upper lane clear");
        fork
            wr(4'hC, 32'h8000_0000);
            pcs_host_model_inst.fire(6'h02);
        join
        exp_fl = 16'h8000;
        rd_chk(6'h01, st(1'b0), "set beats clear");
        {rev23_feature_enable, func_int_pending} = 2'h3;
        repeat (3) @(negedge sys_clk);
        check({31'h0, intx_oe_n}, 32'h0, "interrupt pin on");
        rd_chk(6'h01, st(1'b1), "interrupt status");
        int_disable = 1'b1;
        repeat (3) @(negedge sys_clk);
        check({31'h0, intx_oe_n}, 32'h1, "interrupt pin blocked");
        rd_chk(6'h01, st(1'b1), "status kept while blocked");
        rev23_feature_enable = 1'b0;
        repeat (3) @(negedge sys_clk);
        rd_chk(6'h01, st(1'b0), "status forced zero");
        check({31'h0, intx_oe_n}, 32'h1, "interrupt pin off");
        {rev23_feature_enable, int_disable, func_int_pending} = 3'h4;
        repeat (3) @(negedge sys_clk);
        rd_chk(6'h01, st(1'b0), "no pending interrupt");
        wrap_up();
    end
endmodule

bind pcs_config_status pcs_config_status_properties #(
    .SILICON_VERSION_CODE(SILICON_VERSION_CODE)
) pcs_config_status_properties_inst (.sys_clk, .resetn, .cfg_rd, .cfg_wr, .cfg_idx,
    .cfg_rdata, .cfg_ack, .cfg_hit, .int_disable, .serr_enable, .parity_response_enable,
    .rev23_feature_enable, .addr_parity_err, .data_parity_err, .func_int_pending,
    .devsel_timing, .perr_oe_n, .serr_oe_n, .intx_oe_n);

// ==== verification/pcs_host_model.sv ====
// Host side model: configuration cycles and bus event pulses
`timescale 1ns/1ps
module pcs_host_model (
    input  wire logic        sys_clk,
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic [5:0]       cfg_idx,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_hit,
    output logic [5:0]       ev
);
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_idx = 6'h3F;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
        ev = 6'h00;
    end

    // Request stands through the answer cycle, data is taken mid-answer where it
    // is settled, and the request drops only after the answer edge has passed
    task automatic access(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic hit);
        @(negedge sys_clk);
        cfg_rd = !wr;
        cfg_wr = wr;
        cfg_idx = idx;
        cfg_be = be;
        cfg_wdata = wd;
        @(negedge sys_clk);
        rd = cfg_rdata;
        hit = cfg_hit;
        @(negedge sys_clk);
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_idx = ~idx;
        cfg_wdata = ~wd;
    endtask

    // Bus events last one cycle, as the bus logic reports them
    task automatic fire(input logic [5:0] m);
        @(negedge sys_clk);
        ev = m;
        @(negedge sys_clk);
        ev = 6'h00;
    endtask
endmodule
